// >>> common/iowdt_pkg.sv
// Constants of the I/O port watchdog timer
// Overview of operation
// [RULE_01] Watchdog comes up enabled after reset
// [RULE_02] First port read enables the watchdog
// [RULE_03] Writing 1 enables and restarts interval
// [RULE_04] Expires without refresh within 1.6 s
// [RULE_05] Expiry asserts reset to the CPU
// [RULE_06] Expiry may raise interrupt instead
// [RULE_07] Writing 0 disables the watchdog
// [RULE_08] Interval may deviate plus/minus 30 percent
// [RULE_09] Software should refresh about every second
// [RULE_10] Refresh restarts count; one action per expiry
package iowdt_pkg;
  localparam logic [15:0] IOWDT_PORT_ADDR   = 16'h0443;
  localparam logic [7:0]  IOWDT_DATA_OFF    = 8'h00;
  localparam logic [7:0]  IOWDT_DATA_ON     = 8'h01;
  localparam int          IOWDT_CLK_HZ      = 100_000_000;
  localparam int          IOWDT_TIMEOUT_MS  = 1600;
  localparam int          IOWDT_PRESC_US    = 1000;
  localparam int          IOWDT_PRESC_CYC   =
    IOWDT_CLK_HZ / 1_000_000 * IOWDT_PRESC_US;
  localparam int          IOWDT_TIMEOUT_TCK = IOWDT_TIMEOUT_MS;
  localparam int          IOWDT_PULSE_CYC   = 16;
  localparam int          IOWDT_PW          = 17;
  localparam int          IOWDT_TW          = 11;
  // Status bits returned on a read
  localparam int          IOWDT_ST_EN       = 0;
  localparam int          IOWDT_ST_EXP      = 1;
  localparam int          IOWDT_ST_IRQ      = 2;
endpackage

// >>> common/iowdt_tick_if.sv
// Tick carrier between prescaler and watchdog core
`timescale 1ns/1ps
`default_nettype none
interface iowdt_tick_if;
  logic restart;
  logic tick;
  modport src (input restart, output tick);
  modport dst (output restart, input tick);
endinterface
`default_nettype wire

// >>> rtl/iowdt_presc.sv
// Millisecond tick divider for the watchdog
`timescale 1ns/1ps
`default_nettype none
module iowdt_presc (
  // Clock and reset
  input  wire logic    clk_sys,
  input  wire logic    srst,
  // Tick link
  iowdt_tick_if.src    tk
);
  import iowdt_pkg::*;
  typedef struct packed {
    logic [IOWDT_PW-1:0] cnt;
    logic                tick;
  } iowdt_presc_st_t;
  iowdt_presc_st_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    // Restart realigns phase so a refresh gives a full interval
    if (tk.restart) begin
      next_st.cnt = '0;
    end else if (st.cnt == IOWDT_PW'(IOWDT_PRESC_CYC - 1)) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + IOWDT_PW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tk.tick = st.tick;

  a_tick_period: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (srst)
    st.tick |=> !st.tick [*8])
    else $error("tick repeated too soon");
endmodule
`default_nettype wire

// >>> rtl/iowdt_top.sv
// I/O port watchdog timer with CPU reset or interrupt action
`timescale 1ns/1ps
`default_nettype none
module iowdt_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // I/O port bus
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rvalid,
  // Action select: high chooses interrupt over CPU reset
  input  wire logic        act_irq_sel,
  // Expiry actions
  output logic             cpu_reset,
  output logic             wdt_irq
);
  import iowdt_pkg::*;

  typedef struct packed {
    logic                en;
    logic                expired;
    logic [IOWDT_TW-1:0] ms;
    logic [4:0]          pulse;
    logic                cpu_reset;
    logic                irq;
    logic [7:0]          rdata;
    logic                rvalid;
  } iowdt_st_t;
  iowdt_st_t st, next_st;

  iowdt_tick_if tk ();

  iowdt_presc u_presc (
    .clk_sys (clk_sys),
    .srst    (srst),
    .tk      (tk)
  );

  logic hit;
  logic wr_on;
  logic wr_off;
  logic rd_hit;
  assign hit    = (io_addr == IOWDT_PORT_ADDR);
  assign rd_hit = hit && io_rd;
  assign wr_on  = hit && io_wr && io_wdata == IOWDT_DATA_ON;
  assign wr_off = hit && io_wr && io_wdata == IOWDT_DATA_OFF;
  // The whole byte is decoded; values other than IOWDT_DATA_ON and IOWDT_DATA_OFF are ignored
  assign tk.restart = wr_on || (rd_hit && !st.en);

  always_comb begin
    next_st = st;
    next_st.rvalid = rd_hit;
    if (rd_hit) begin
      next_st.rdata = '0;
      next_st.rdata[IOWDT_ST_EN]  = st.en;
      next_st.rdata[IOWDT_ST_EXP] = st.expired;
      next_st.rdata[IOWDT_ST_IRQ] = act_irq_sel;
    end
    if (st.pulse != '0) begin
      next_st.pulse = st.pulse - 5'd1;
    end else begin
      next_st.cpu_reset = 1'b0;
      next_st.irq       = 1'b0;
    end

    // [RULE_04] count interval ticks
    if (st.en && !st.expired && tk.tick) begin
      // [RULE_08] exact nominal length
      // Sits mid-tolerance, so software margins hold either way
      if (st.ms == IOWDT_TW'(IOWDT_TIMEOUT_TCK - 1)) begin
        next_st.expired = 1'b1;
        next_st.pulse   = 5'(IOWDT_PULSE_CYC - 1);
        // [RULE_05] reset CPU, or [RULE_06] interrupt
        next_st.cpu_reset = !act_irq_sel;
        next_st.irq       = act_irq_sel;
      end else begin
        next_st.ms = st.ms + IOWDT_TW'(1);
      end
    end

    // [RULE_02] first read arms the timer
    if (rd_hit && !st.en) begin
      next_st.en = 1'b1;
      next_st.ms = '0;
      next_st.expired = 1'b0;
    end

    // [RULE_03] [RULE_10] refresh restarts from zero
    if (wr_on) begin
      next_st.en      = 1'b1;
      next_st.ms      = '0;
      next_st.expired = 1'b0;
    end

    // [RULE_07] disable stops the count; a reset or interrupt pulse already set still runs out
    if (wr_off) begin
      next_st.en      = 1'b0;
      next_st.ms      = '0;
      next_st.expired = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st    <= '0;
      // [RULE_01] enabled out of reset
      st.en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign io_rdata  = st.rdata;
  assign io_rvalid = st.rvalid;
  assign cpu_reset = st.cpu_reset;
  assign wdt_irq   = st.irq;

  // Checks on the port decode and the expiry action
  // Expiry itself is too far out for a bench to reach

  a_off_quiet: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (srst)
    wr_off |=> !st.en && !st.expired)
    else $error("disable write did not stop timer");

  a_on_restart: assert property ( // [RULE_03]
    @(posedge clk_sys) disable iff (srst)
    wr_on && !wr_off |=> st.en && st.ms == '0)
    else $error("refresh did not restart count");

  a_read_arms: assert property ( // [RULE_02]
    @(posedge clk_sys) disable iff (srst)
    rd_hit && !st.en && !wr_off |=> st.en)
    else $error("read did not enable timer");

  a_expire_rst: assert property ( // [RULE_05]
    @(posedge clk_sys) disable iff (srst)
    $rose(st.expired) && !$past(act_irq_sel) |-> cpu_reset [*8])
    else $error("expiry reset pulse missing");

  a_expire_irq: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (srst)
    $rose(st.expired) |-> (wdt_irq != cpu_reset))
    else $error("expiry action not exclusive");

  a_once_only: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (srst)
    st.expired && $past(st.expired) |-> !$rose(cpu_reset))
    else $error("expiry action repeated");

  a_timeout_at: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (srst)
    $rose(st.expired) |->
      $past(st.ms) == IOWDT_TW'(IOWDT_TIMEOUT_TCK - 1))
    else $error("expiry at wrong count");

  a_reset_en: assert property ( // [RULE_01]
    @(posedge clk_sys)
    $past(srst) |-> st.en && !st.expired && st.ms == '0)
    else $error("not enabled after reset");

  a_rst_width: assert property ( // [RULE_05]
    @(posedge clk_sys) disable iff (srst)
    $rose(st.expired) && !$past(act_irq_sel) |->
      cpu_reset [*8] ##1 cpu_reset [*8] ##1 !cpu_reset)
    else $error("reset pulse has wrong length");

  a_irq_width: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (srst)
    $rose(st.expired) && $past(act_irq_sel) |->
      wdt_irq [*8] ##1 wdt_irq [*8] ##1 !wdt_irq)
    else $error("interrupt pulse has wrong length");

  a_sel_status: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (srst)
    rd_hit |=> io_rdata[IOWDT_ST_IRQ] == $past(act_irq_sel))
    else $error("action select misreported");

  a_off_no_act: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (srst)
    !st.en |=> !$rose(cpu_reset) && !$rose(wdt_irq))
    else $error("action while disabled");

  a_rvalid_pulse: assert property ( // [RULE_02]
    @(posedge clk_sys) disable iff (srst)
    rd_hit |=> io_rvalid)
    else $error("read not answered");

  a_rvalid_idle: assert property ( // [RULE_02]
    @(posedge clk_sys) disable iff (srst)
    !rd_hit |=> !io_rvalid)
    else $error("answer without read");

  a_exp_needs_en: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (srst)
    st.expired |-> st.en)
    else $error("expired while disabled");

  a_refresh_clear: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (srst)
    wr_on |=> !st.expired)
    else $error("refresh left expiry set");

  a_exp_hold: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (srst)
    st.expired && !wr_on && !wr_off |=> st.expired)
    else $error("expiry cleared on its own");

  a_count_frozen: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (srst)
    st.expired && !wr_on && !wr_off |=> $stable(st.ms))
    else $error("count moved after expiry");

  a_status_en: assert property ( // [RULE_01]
    @(posedge clk_sys) disable iff (srst)
    rd_hit |=> io_rdata[IOWDT_ST_EN] == $past(st.en))
    else $error("enable misreported");

  a_status_exp: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (srst)
    rd_hit |=> io_rdata[IOWDT_ST_EXP] == $past(st.expired))
    else $error("expiry misreported");
endmodule
`default_nettype wire

// >>> tb/iowdt_tb_top.sv
// Self-checking bench for the I/O port watchdog timer
`timescale 1ns/1ps
`default_nettype none
module iowdt_tb_top;
  import iowdt_pkg::*;
  logic        clk_sys;
  logic        srst;
  logic [15:0] io_addr;
  logic        io_rd;
  logic        io_wr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_rvalid;
  logic        act_irq_sel;
  logic        cpu_reset;
  logic        wdt_irq;
  logic [7:0]  d;
  logic        v;
  int          num_errors;
  int          compares;

  iowdt_top iowdt_top_inst (
    .clk_sys(clk_sys), .srst(srst), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .act_irq_sel(act_irq_sel),
    .cpu_reset(cpu_reset), .wdt_irq(wdt_irq));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: byte %h not %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    io_addr  <= a;
    io_wdata <= x;
    io_wr    <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
  endtask

  // Answer lands one cycle after the strobe edge
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    #1;
    v = io_rvalid;
    d = io_rdata;
  endtask

  task automatic test_reset;
    rd(IOWDT_PORT_ADDR);
    check1(v, 1'b1);
    check8(d, 8'h01);
    $display("test_reset done");
  endtask

  // Disable, stray writes, then reads re-arm the timer
  task automatic test_disable_arm;
    wr(IOWDT_PORT_ADDR, IOWDT_DATA_OFF);
    wr(IOWDT_PORT_ADDR, 8'h02);
    wr(16'h0442, IOWDT_DATA_ON);
    rd(16'h0442);
    check1(v, 1'b0);
    rd(IOWDT_PORT_ADDR);
    check1(v, 1'b1);
    check8(d, 8'h00);
    rd(IOWDT_PORT_ADDR);
    check8(d, 8'h01);
    $display("test_disable_arm done");
  endtask

  task automatic test_refresh;
    for (int i = 0; i < 4; i++) begin
      wr(IOWDT_PORT_ADDR, IOWDT_DATA_ON);
    end
    rd(IOWDT_PORT_ADDR);
    check8(d, 8'h01);
    check1(cpu_reset, 1'b0);
    $display("test_refresh done");
  endtask

  // Reset in mid-run brings the timer back enabled
  task automatic test_mid_reset;
    wr(IOWDT_PORT_ADDR, IOWDT_DATA_OFF);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rd(IOWDT_PORT_ADDR);
    check1(v, 1'b1);
    check8(d, 8'h01);
    check1(cpu_reset, 1'b0);
    $display("test_mid_reset done");
  endtask

  task automatic test_irq_sel;
    @(posedge clk_sys);
    act_irq_sel <= 1'b1;
    rd(IOWDT_PORT_ADDR);
    check8(d, 8'h05);
    check1(wdt_irq, 1'b0);
    $display("test_irq_sel done");
  endtask

  task automatic print_verdict;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end

  initial begin
    num_errors = 0;
    compares = 0;
    srst = 1'b1;
    io_addr = 16'h0000;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
    act_irq_sel = 1'b0;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    test_reset();
    test_disable_arm();
    test_refresh();
    test_mid_reset();
    test_irq_sel();
    print_verdict();
  end
endmodule
`default_nettype wire
